// File: eii_consts.svh
// Constants of the instruction interpreter: opcodes, field positions, reset values.
// Assumes inclusion by bare name from the package and design files.
`ifndef EII_CONSTS_SVH
`define EII_CONSTS_SVH
`define EII_OP_XFER_MAX 8'h7F
`define EII_OP_APPLY 8'h80
`define EII_OP_CAL_ALL 8'h90
`define EII_OP_CAL_SYS 8'h91
`define EII_OP_CAL_AP0 8'h92
`define EII_OP_CAL_AP1 8'h93
`define EII_OP_FR_ALL 8'h98
`define EII_OP_FR_DL0 8'h99
`define EII_OP_FR_DL1 8'h9A
`define EII_OP_SYNC_ALL 8'hA0
`define EII_OP_SYNC_CH0 8'hA1
`define EII_OP_SYNC_CH1 8'hA2
`define EII_OP_COND_BASE 8'hB0
`define EII_OP_COND_HI_NIB 4'hB
`define EII_OP_PAUSE 8'hFE
`define EII_OP_END 8'hFF
`define EII_XFER_FLAG_BIT 7
`define EII_ADDR_RESET 16'h0000
`define EII_MAP_RESET 16'h0000
`endif

// File: eii_pkg.sv
// Types shared by the instruction interpreter files.
// Assumes eii_consts.svh sits in the same folder.
`include "eii_consts.svh"
package eii_pkg;
  typedef enum logic [3:0] {
    EII_IDLE,
    EII_OPC,
    EII_ADH,
    EII_ADL,
    EII_DATA,
    EII_CRC,
    EII_DONE
  } eii_state_e;
  typedef enum logic [1:0] {
    EII_MODE_NONE,
    EII_MODE_DOWN,
    EII_MODE_UP
  } eii_mode_e;
  typedef logic [7:0] eii_byte_t;
endpackage

// File: eii_cond.sv
// Condition map and skip decision of the instruction interpreter.
// Assumes single clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "eii_consts.svh"
module eii_cond
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic cond_hit,
  input wire logic [3:0] cond_value,
  input wire logic [3:0] cond_id,
  output logic skip
);
  typedef struct packed {
    logic [15:0] map;
  } eii_cond_s;
  eii_cond_s st_r;
  eii_cond_s st_nxt;
  logic in_map;
  // ------------------------------------------------------------------
  // Map update.
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (clear)
    begin
      st_nxt.map = `EII_MAP_RESET;
    end
    else if (cond_hit)
    begin
      if (cond_value == 4'h0)
      begin
        st_nxt.map = `EII_MAP_RESET;
      end
      else
      begin
        st_nxt.map[cond_value] = 1'b1;
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r <= '{map: `EII_MAP_RESET};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  // ------------------------------------------------------------------
  // Skip when ID nonzero, map not empty and ID absent.
  // ------------------------------------------------------------------
  assign in_map = st_r.map[cond_id];
  assign skip = (cond_id != 4'h0) && (st_r.map != `EII_MAP_RESET) && !in_map;
endmodule
`default_nettype wire

// File: eii_decode.sv
// Opcode decoder for the instruction interpreter.
// Assumes a byte in, combinational flags out.
`timescale 1ns/1ps
`default_nettype none
`include "eii_consts.svh"
module eii_decode
(
  input wire logic [7:0] opc,
  output logic is_xfer,
  output logic is_cond,
  output logic [5:0] action
);
  // ------------------------------------------------------------------
  // Classes and device action mask (EII_OP_CAL_ALL and EII_OP_FR_ALL set several bits; every sync opcode sets bit 5 only).
  // ------------------------------------------------------------------
  assign is_xfer = (opc[`EII_XFER_FLAG_BIT] == 1'b0);
  assign is_cond = (opc[7:4] == `EII_OP_COND_HI_NIB);
  always_comb
  begin
    action = 6'b00_0000;
    case (opc)
      `EII_OP_CAL_ALL: action = 6'b00_0111;
      `EII_OP_CAL_SYS: action = 6'b00_0001;
      `EII_OP_CAL_AP0: action = 6'b00_0010;
      `EII_OP_CAL_AP1: action = 6'b00_0100;
      `EII_OP_FR_ALL: action = 6'b01_1000;
      `EII_OP_FR_DL0: action = 6'b00_1000;
      `EII_OP_FR_DL1: action = 6'b01_0000;
      `EII_OP_SYNC_ALL: action = 6'b10_0000;
      `EII_OP_SYNC_CH0: action = 6'b10_0000;
      `EII_OP_SYNC_CH1: action = 6'b10_0000;
      default: action = 6'b00_0000;
    endcase
  end
endmodule
`default_nettype wire

// File: eii_interp.sv
// Top of the instruction interpreter: steps download bytes and upload bytes.
// Assumes a byte source with valid/ready, a register port and a memory sink,
// all on the same clock; transport, checksum and header logic lie outside.
`timescale 1ns/1ps
`default_nettype none
`include "eii_consts.svh"
module eii_interp
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start_download,
  input wire logic start_upload,
  input wire logic [3:0] cond_id,
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  output logic in_ready,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [7:0] crc_byte,
  output logic crc_check,
  output logic apply_pulse,
  output logic [2:0] cal_pulse,
  output logic [1:0] freerun_pulse,
  output logic [1:0] sync_pulse,
  output logic busy,
  output logic paused,
  output eii_pkg::eii_mode_e mode
);
  import eii_pkg::*;
  typedef struct packed {
    eii_state_e state;
    eii_mode_e mode;
    logic [15:0] ptr;
    logic [15:0] addr;
    logic [7:0] count;
    logic [7:0] opc;
    logic skipping;
    logic paused;
    logic [1:0] crc_left;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] wdata;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [7:0] mem_data;
    logic crc_check;
    logic apply;
    logic [2:0] cal;
    logic [1:0] fr;
    logic [1:0] sync;
  } eii_top_s;
  eii_top_s st_r;
  eii_top_s st_nxt;
  logic is_xfer;
  logic is_cond;
  logic [5:0] action;
  logic skip;
  logic cond_hit;
  logic map_clear;
  logic take;
  logic up_ok;
  logic [1:0] sync_sel;
  // ------------------------------------------------------------------
  // Decoder and condition map.
  // ------------------------------------------------------------------
  eii_decode u_dec
  (
    .opc(in_byte),
    .is_xfer(is_xfer),
    .is_cond(is_cond),
    .action(action)
  );
  eii_cond u_cond
  (
    .clock(clock),
    .rst(rst),
    .clear(map_clear),
    .cond_hit(cond_hit),
    .cond_value(in_byte[3:0]),
    .cond_id(cond_id),
    .skip(skip)
  );
  // ------------------------------------------------------------------
  // Handshake terms.
  // ------------------------------------------------------------------
  assign up_ok = !st_r.mem_wr || mem_ready;
  always_comb
  begin
    in_ready = 1'b0;
    case (st_r.state)
      EII_OPC, EII_ADH, EII_ADL: in_ready = (st_r.mode == EII_MODE_DOWN) || up_ok;
      EII_DATA: in_ready = (st_r.mode == EII_MODE_DOWN);
      default: in_ready = 1'b0;
    endcase
  end
  assign take = in_valid && in_ready;
  assign cond_hit = take && (st_r.state == EII_OPC) && is_cond
    && (st_r.mode == EII_MODE_DOWN);
  assign map_clear = (st_r.state == EII_IDLE) && start_download;
  // ------------------------------------------------------------------
  // Channel select of the synchronize opcodes.
  // ------------------------------------------------------------------
  always_comb
  begin
    sync_sel = 2'b00;
    case (in_byte)
      `EII_OP_SYNC_ALL: sync_sel = 2'b11;
      `EII_OP_SYNC_CH0: sync_sel = 2'b01;
      `EII_OP_SYNC_CH1: sync_sel = 2'b10;
      default: sync_sel = 2'b00;
    endcase
  end
  // ------------------------------------------------------------------
  // Sequencer.
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.reg_wr = 1'b0;
    st_nxt.reg_rd = 1'b0;
    st_nxt.crc_check = 1'b0;
    st_nxt.apply = 1'b0;
    st_nxt.cal = 3'b000;
    st_nxt.fr = 2'b00;
    st_nxt.sync = 2'b00;
    if (st_r.mem_wr && mem_ready)
    begin
      st_nxt.mem_wr = 1'b0;
    end
    case (st_r.state)
      EII_IDLE:
      begin
        if (start_download)
        begin
          st_nxt.state = EII_OPC;
          st_nxt.mode = EII_MODE_DOWN;
          st_nxt.ptr = `EII_ADDR_RESET;
          st_nxt.skipping = 1'b0;
          st_nxt.paused = 1'b0;
        end
        else if (start_upload)
        begin
          st_nxt.state = EII_OPC;
          st_nxt.mode = EII_MODE_UP;
          st_nxt.paused = 1'b0;
        end
      end
      EII_OPC:
      begin
        if (take)
        begin
          st_nxt.opc = in_byte;
          if (st_r.mode == EII_MODE_UP)
          begin
            st_nxt.mem_wr = 1'b1;
            st_nxt.mem_addr = st_r.ptr;
            st_nxt.mem_data = in_byte;
            st_nxt.ptr = st_r.ptr + 16'h0001;
            if (in_byte == `EII_OP_PAUSE)
            begin
              st_nxt.mem_wr = 1'b0;
              st_nxt.ptr = st_r.ptr;
              st_nxt.state = EII_IDLE;
              st_nxt.mode = EII_MODE_NONE;
              st_nxt.paused = 1'b1;
            end
            else if (in_byte == `EII_OP_END)
            begin
              st_nxt.state = EII_CRC;
              st_nxt.crc_left = 2'b11;
            end
            else if (is_xfer)
            begin
              st_nxt.state = EII_ADH;
              st_nxt.count = in_byte;
            end
          end
          else
          begin
            st_nxt.ptr = st_r.ptr + 16'h0001;
            st_nxt.skipping = skip;
            if (in_byte == `EII_OP_END)
            begin
              st_nxt.ptr = `EII_ADDR_RESET;
              st_nxt.crc_check = 1'b1;
              st_nxt.state = EII_DONE;
            end
            else if (is_xfer)
            begin
              st_nxt.state = EII_ADH;
              st_nxt.count = in_byte;
            end
            else if (!is_cond && !skip)
            begin
              st_nxt.apply = (in_byte == `EII_OP_APPLY);
              st_nxt.cal = action[2:0];
              st_nxt.fr = action[4:3];
              st_nxt.sync = action[5] ? sync_sel : 2'b00;
            end
          end
        end
      end
      EII_ADH:
      begin
        if (take)
        begin
          st_nxt.addr[15:8] = in_byte;
          st_nxt.state = EII_ADL;
          if (st_r.mode == EII_MODE_UP)
          begin
            st_nxt.mem_wr = 1'b1;
            st_nxt.mem_addr = st_r.ptr;
            st_nxt.mem_data = in_byte;
          end
          st_nxt.ptr = st_r.ptr + 16'h0001;
        end
      end
      EII_ADL:
      begin
        if (take)
        begin
          st_nxt.addr[7:0] = in_byte;
          st_nxt.state = EII_DATA;
          if (st_r.mode == EII_MODE_UP)
          begin
            st_nxt.mem_wr = 1'b1;
            st_nxt.mem_addr = st_r.ptr;
            st_nxt.mem_data = in_byte;
            st_nxt.reg_rd = 1'b1;
          end
          st_nxt.ptr = st_r.ptr + 16'h0001;
        end
      end
      EII_DATA:
      begin
        if (st_r.mode == EII_MODE_DOWN)
        begin
          if (take)
          begin
            st_nxt.reg_wr = !st_r.skipping;
            st_nxt.wdata = in_byte;
            st_nxt.ptr = st_r.ptr + 16'h0001;
            if (st_r.reg_wr)
            begin
              st_nxt.addr = st_r.addr + 16'h0001;
            end
            if (st_r.count == 8'h00)
            begin
              st_nxt.state = EII_OPC;
            end
            st_nxt.count = st_r.count - 8'h01;
          end
          else if (st_r.reg_wr)
          begin
            st_nxt.addr = st_r.addr + 16'h0001;
          end
        end
        else if (up_ok && !st_r.reg_rd)
        begin
          st_nxt.mem_wr = 1'b1;
          st_nxt.mem_addr = st_r.ptr;
          st_nxt.mem_data = reg_rdata;
          st_nxt.ptr = st_r.ptr + 16'h0001;
          st_nxt.addr = st_r.addr + 16'h0001;
          st_nxt.count = st_r.count - 8'h01;
          if (st_r.count == 8'h00)
          begin
            st_nxt.state = EII_OPC;
          end
          else
          begin
            st_nxt.reg_rd = 1'b1;
          end
        end
      end
      EII_CRC:
      begin
        if (up_ok)
        begin
          st_nxt.mem_wr = 1'b1;
          st_nxt.mem_addr = st_r.ptr;
          st_nxt.mem_data = crc_byte;
          st_nxt.ptr = st_r.ptr + 16'h0001;
          st_nxt.crc_left = st_r.crc_left - 2'b01;
          if (st_r.crc_left == 2'b00)
          begin
            st_nxt.ptr = `EII_ADDR_RESET;
            st_nxt.state = EII_DONE;
          end
        end
      end
      EII_DONE:
      begin
        if (!st_r.mem_wr)
        begin
          st_nxt.state = EII_IDLE;
          st_nxt.mode = EII_MODE_NONE;
        end
      end
      default: st_nxt.state = EII_IDLE;
    endcase
  end
  // ------------------------------------------------------------------
  // State register.
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  // ------------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------------
  assign reg_wr = st_r.reg_wr;
  assign reg_rd = st_r.reg_rd;
  assign reg_addr = st_r.addr;
  assign reg_wdata = st_r.wdata;
  assign mem_wr = st_r.mem_wr;
  assign mem_addr = st_r.mem_addr;
  assign mem_wdata = st_r.mem_data;
  assign crc_check = st_r.crc_check;
  assign apply_pulse = st_r.apply;
  assign cal_pulse = st_r.cal;
  assign freerun_pulse = st_r.fr;
  assign sync_pulse = st_r.sync;
  assign busy = (st_r.state != EII_IDLE);
  assign paused = st_r.paused;
  assign mode = st_r.mode;
endmodule
`default_nettype wire

// File: eii_interp_assertions.sv
// Concurrent checks on the ports of the instruction interpreter top.
// Assumes a bind onto eii_interp, one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module eii_interp_assertions
  import eii_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic reg_wr,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic crc_check,
  input wire logic apply_pulse,
  input wire logic [2:0] cal_pulse,
  input wire logic [1:0] freerun_pulse,
  input wire logic [1:0] sync_pulse,
  input wire logic busy,
  input wire logic paused,
  input wire eii_mode_e mode
);
  // ------------------------------------------------------------
  // Helper logic and properties.
  // ------------------------------------------------------------
  logic take_dn;
  assign take_dn = in_valid && in_ready && mode == EII_MODE_DOWN;
  function automatic logic [6:0] act_of(input logic [7:0] b);
    case (b)
      8'h90: return 7'h70;
      8'h91: return 7'h10;
      8'h92: return 7'h20;
      8'h93: return 7'h40;
      8'h98: return 7'h0C;
      8'h99: return 7'h04;
      8'h9A: return 7'h08;
      8'hA0: return 7'h03;
      8'hA1: return 7'h01;
      8'hA2: return 7'h02;
      default: return 7'h00;
    endcase
  endfunction
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_reg_wr_take: assert property (reg_wr |-> $past(take_dn))
    else $error("register write without a taken byte");
  a_apply_cause:
    assert property (apply_pulse |-> $past(take_dn) && $past(in_byte) == 8'h80)
    else $error("apply pulse without its opcode");
  a_cal_code:
    assert property ((|cal_pulse) |-> $past(take_dn)
      && {cal_pulse, 4'h0} == act_of($past(in_byte)))
    else $error("calibration pulse does not match opcode");
  a_freerun_code:
    assert property ((|freerun_pulse) |-> $past(take_dn)
      && {3'h0, freerun_pulse, 2'h0} == act_of($past(in_byte)))
    else $error("freerun pulse does not match opcode");
  a_sync_code:
    assert property ((|sync_pulse) |-> $past(take_dn)
      && {5'h00, sync_pulse} == act_of($past(in_byte)))
    else $error("sync pulse does not match opcode");
  a_mem_wr_hold:
    assert property (mem_wr && !mem_ready |=> mem_wr && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory write dropped or changed before acceptance");
  a_end_stops:
    assert property (crc_check |-> $past(take_dn) && $past(in_byte) == 8'hFF ##1 !busy)
    else $error("end of data not followed by idle");
  a_pause_idle: assert property (paused |-> !busy)
    else $error("paused while busy");
  a_up_no_reg_wr: assert property (mode == EII_MODE_UP |-> !reg_wr)
    else $error("register write during upload");
  c_reg_wr: cover property (reg_wr);
  c_end: cover property (crc_check);
  c_pause: cover property ($rose(paused));
  c_stall: cover property (mem_wr && !mem_ready);
endmodule
`default_nettype wire

// File: eii_mem_model.sv
// Model of the memory side: an instruction byte source and a write sink.
// Assumes the bench queues bytes through load while the block is idle.
`timescale 1ns/1ps
`default_nettype none
module eii_mem_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic in_ready,
  output logic [7:0] in_byte,
  output logic in_valid,
  output logic mem_ready
);
  // ------------------------------------------------------------
  // Byte source, held until taken, and a stalling write sink.
  // ------------------------------------------------------------
  logic [7:0] q[$];
  task automatic load(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial
  begin
    in_byte = 8'h00;
    in_valid = 1'b0;
    mem_ready = 1'b0;
  end
  always @(posedge clock)
  begin
    mem_ready <= !rst && !stall;
    if (rst)
    begin
      in_valid <= 1'b0;
      in_byte <= ~in_byte;
    end
    else if (!in_valid || in_ready)
    begin
      if (in_valid)
        void'(q.pop_front());
      if (q.size() != 0 && !stall)
      begin
        in_valid <= 1'b1;
        in_byte <= q[0];
      end
      else
      begin
        in_valid <= 1'b0;
        in_byte <= ~in_byte;
      end
    end
  end
endmodule
`default_nettype wire

// File: eii_interp_test.sv
// Self-checking bench of the instruction interpreter.
// Assumes eii_mem_model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module eii_interp_test;
  import eii_pkg::*;
  logic clock, rst, start_download, start_upload, stall, in_valid, in_ready, reg_wr, reg_rd;
  logic mem_wr, mem_ready, crc_check, apply_pulse, busy, paused;
  logic [3:0] cond_id;
  logic [7:0] in_byte, reg_wdata, reg_rdata, mem_wdata, crc_byte, seed, rd, cr;
  logic [15:0] reg_addr, mem_addr;
  logic [2:0] cal_pulse;
  logic [1:0] freerun_pulse, sync_pulse;
  eii_mode_e mode;
  logic [34:0] exp_q[$];
  logic [34:0] ev;
  logic [7:0] acts[10] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h98, 8'h99, 8'h9A, 8'hA0, 8'hA1, 8'hA2};
  logic [6:0] hits[10] = '{7'h70, 7'h10, 7'h20, 7'h40, 7'h0C, 7'h04, 7'h08, 7'h03, 7'h01, 7'h02};
  logic [7:0] s1[15] = '{8'h81, 8'hC5, 8'hFE, 8'hAF, 8'hB1, 8'h00, 8'h55, 8'h66, 8'h77, 8'h91,
    8'hB2, 8'h92, 8'hB0, 8'h93, 8'hFF};
  logic [7:0] s2[6] = '{8'hB5, 8'h00, 8'hAB, 8'hCD, 8'h5A, 8'hFF};
  logic [7:0] ups[8] = '{8'h01, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'hB3, 8'h91};
  int n_fail, comparisons;

  // ------------------------------------------------------------
  // Design, memory model, tasks and scenarios.
  // ------------------------------------------------------------
  eii_interp DUT (.clock, .rst, .start_download, .start_upload, .cond_id, .in_byte, .in_valid,
    .in_ready, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .mem_wr, .mem_addr,
    .mem_wdata, .mem_ready, .crc_byte, .crc_check, .apply_pulse, .cal_pulse, .freerun_pulse,
    .sync_pulse, .busy, .paused, .mode);
  eii_mem_model u_mem (.clock, .rst, .stall, .in_ready, .in_byte, .in_valid, .mem_ready);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic finish_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [34:0] got, input logic [34:0] exp_v);
    comparisons++;
    if (got !== exp_v)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp_v);
      n_fail++;
    end
  endtask
  task automatic want(input logic [10:0] f, input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({f, a, d});
  endtask
  task automatic run(input logic dn);
    int i;
    @(posedge clock);
    start_download <= dn;
    start_upload <= !dn;
    @(posedge clock);
    start_download <= 1'b0;
    start_upload <= 1'b0;
    repeat (2) @(posedge clock);
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clock);
    if (i == 3000)
    begin
      n_fail++;
      finish_test();
    end
    repeat (2) @(posedge clock);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    seed <= lfsr(seed);
    stall <= seed[1] & seed[4];
  end
  // Register map read port and checksum engine seen by the upload path.
  always @(posedge clock)
  begin
    if (reg_rd)
      reg_rdata <= reg_addr[7:0] ^ rd;
    if (mem_wr && mem_ready)
      crc_byte <= crc_byte + 8'h11;
  end
  // Every output event takes the oldest expected note off the queue.
  always @(posedge clock)
  begin
    ev = {reg_wr, crc_check, apply_pulse, cal_pulse, freerun_pulse, sync_pulse,
      mem_wr && mem_ready, reg_wr ? reg_addr : mem_wr ? mem_addr : 16'h0000,
      reg_wr ? reg_wdata : mem_wr ? mem_wdata : 8'h00};
    if (!rst && ev[34:24] !== 11'h000)
    begin
      if (exp_q.size() == 0)
        check(ev, ~ev);
      else
        check(ev, exp_q.pop_front());
    end
  end

  initial
  begin
    rst = 1'b1;
    start_download = 1'b0;
    start_upload = 1'b0;
    cond_id = 4'h2;
    reg_rdata = 8'h00;
    crc_byte = 8'h00;
    seed = 8'h0E;
    stall = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    u_mem.load(8'h01);
    u_mem.load(8'h12);
    u_mem.load(8'h34);
    u_mem.load(seed);
    u_mem.load(~seed);
    want(11'h400, 16'h1234, seed);
    want(11'h400, 16'h1235, ~seed);
    u_mem.load(8'h80);
    want(11'h100, 16'h0000, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      u_mem.load(acts[i]);
      want({3'h0, hits[i], 1'b0}, 16'h0000, 8'h00);
    end
    for (int i = 0; i < 15; i++)
      u_mem.load(s1[i]);
    want(11'h040, 16'h0000, 8'h00);
    want(11'h080, 16'h0000, 8'h00);
    want(11'h200, 16'h0000, 8'h00);
    run(1'b1);
    cond_id <= 4'h0;
    for (int i = 0; i < 6; i++)
      u_mem.load(s2[i]);
    want(11'h400, 16'hABCD, 8'h5A);
    want(11'h200, 16'h0000, 8'h00);
    run(1'b1);
    rd = seed;
    cr = ~seed;
    for (int i = 0; i < 8; i++)
    begin
      if (i != 3 && i != 4)
        u_mem.load(ups[i]);
      want(11'h001, 16'(i), (i == 3 || i == 4) ? rd ^ 8'(i - 3) : ups[i]);
    end
    u_mem.load(8'hFE);
    run(1'b0);
    check({34'h0, paused}, 35'h1);
    crc_byte <= cr;
    u_mem.load(8'hFF);
    want(11'h001, 16'h0008, 8'hFF);
    for (int i = 9; i < 13; i++)
      want(11'h001, 16'(i), cr + 8'(17 * (i - 9)));
    run(1'b0);
    check(35'(exp_q.size()), 35'h0);
    finish_test();
  end
endmodule

bind eii_interp eii_interp_assertions u_chk (.clock, .rst, .in_byte, .in_valid, .in_ready,
  .reg_wr, .mem_wr, .mem_addr, .mem_wdata, .mem_ready, .crc_check, .apply_pulse, .cal_pulse,
  .freerun_pulse, .sync_pulse, .busy, .paused, .mode);
`default_nettype wire
